/* File: logic/mss_pkg.sv */
package mss_pkg;

	// ----------------------------------------
	// Clock rates
	// ----------------------------------------
	localparam int MSS_MCLK_HZ        = 40000000;
	localparam int MSS_SCLK_HALF_CYC  = 14;

	// ----------------------------------------
	// Link timing in printed units
	// ----------------------------------------
	localparam int MSS_RD_ADDR_DATA_GAP_US = 35;
	localparam int MSS_WR_WR_GAP_US        = 45;
	localparam int MSS_WRITE_TO_READ_GAP_US = 45;
	localparam int MSS_READ_TO_CMD_GAP_US  = 20;
	localparam int MSS_WR_CS_HOLD_US       = 35;
	localparam int MSS_BURST_EXIT_NS       = 500;
	localparam int MSS_RESET_TO_MOTION_MS  = 50;
	localparam int MSS_SHUTDOWN_SETTLE_US  = 500;
	localparam int MSS_HW_RESET_PULSE_US   = 10;

	// ----------------------------------------
	// Cycle counts, least times rounded up
	// ----------------------------------------
	localparam int MSS_CYC_PER_US = MSS_MCLK_HZ / 1000000;
	localparam int MSS_READ_ADDR_DATA_GAP = MSS_RD_ADDR_DATA_GAP_US * MSS_CYC_PER_US;
	localparam int MSS_WRITE_WRITE_GAP    = MSS_WR_WR_GAP_US * MSS_CYC_PER_US;
	localparam int MSS_WRITE_TO_READ_GAP  = MSS_WRITE_TO_READ_GAP_US * MSS_CYC_PER_US;
	localparam int MSS_READ_TO_WRITE_GAP  = MSS_READ_TO_CMD_GAP_US * MSS_CYC_PER_US;
	localparam int MSS_READ_TO_READ_GAP   = MSS_READ_TO_CMD_GAP_US * MSS_CYC_PER_US;
	localparam int MSS_WR_CS_HOLD         = MSS_WR_CS_HOLD_US * MSS_CYC_PER_US;
	localparam int MSS_BURST_EXIT         = (MSS_BURST_EXIT_NS * MSS_CYC_PER_US + 999) / 1000;
	localparam int MSS_HW_RESET_PULSE     = MSS_HW_RESET_PULSE_US * MSS_CYC_PER_US;
	// Device settle counts engine clocks, sized for a 1 MHz clock; time is exact at 1 MHz and shorter at any faster clock
	localparam int MSS_LINK_MIN_HZ        = 1000000;
	localparam int MSS_SHUTDOWN_SETTLE    = MSS_SHUTDOWN_SETTLE_US * (MSS_LINK_MIN_HZ / 1000000);
	localparam int MSS_RESET_TO_MOTION_HOST = MSS_RESET_TO_MOTION_MS * 1000 * MSS_CYC_PER_US;

	// ----------------------------------------
	// Command format
	// ----------------------------------------
	localparam int         MSS_BYTE_W     = 8;
	localparam int         MSS_WRITE_BIT  = 7;
	localparam logic [6:0] MSS_ADDR_SHUTDOWN = 7'h3B;
	localparam logic [6:0] MSS_ADDR_PWR_RESET = 7'h3A;
	localparam logic [6:0] MSS_ADDR_MOTION_BURST = 7'h16;

	typedef enum logic [1:0]
	{
		MSS_LAST_NONE,
		MSS_LAST_WRITE,
		MSS_LAST_READ,
		MSS_LAST_BURST
	} mss_last_t;

endpackage

/* File: logic/mss_link_if.sv */
`timescale 1ns/1ps
interface mss_link_if;

	// ----------------------------------------
	// Serial link signals
	// ----------------------------------------
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic hw_reset_n;

	modport host
	(
		output sclk,
		output cs_n,
		output mosi,
		output hw_reset_n,
		input  miso,
		input  miso_oe
	);

	modport sensor
	(
		input  sclk,
		input  cs_n,
		input  mosi,
		input  hw_reset_n,
		output miso,
		output miso_oe
	);

endinterface

/* File: logic/mss_sensor.sv */
`timescale 1ns/1ps
module mss_sensor
	import mss_pkg::*;
(
	// Link
	mss_link_if.sensor             link,
	// Motion engine clock and reset
	input  wire logic              mclk_in,
	input  wire logic              rst_n_in,
	// Register file access
	output logic                   wr_stb_out,
	output logic [6:0]             wr_addr_out,
	output logic [7:0]             wr_data_out,
	output logic [6:0]             rd_addr_out,
	input  wire logic [7:0]        rd_data_in,
	// Status
	output logic                   shutdown_out,
	output logic                   low_power_out,
	output logic                   motion_valid_out
);

	// ----------------------------------------
	// Link domain: shift engine
	// ----------------------------------------
	logic                rst_n;
	logic [2:0]          bit_cnt_q;
	logic [7:0]          shift_q;
	logic [6:0]          addr_q;
	logic                is_write_q;
	logic                phase_q;
	logic [7:0]          tx_q;
	logic                wr_tgl_q;
	logic [7:0]          wdata_q;
	logic                sd_q;
	logic [8:0]          settle_cnt_q;
	logic                lowp_q;
	wire  logic [7:0]    shift_d   = {shift_q[6:0], link.mosi};
	wire  logic          byte_done = (bit_cnt_q == 3'h7);
	wire  logic          wr_sd     = is_write_q && (addr_q == MSS_ADDR_SHUTDOWN);

	assign rst_n = rst_n_in & link.hw_reset_n;

	// Capture on rising edge
	always_ff @(posedge link.sclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_cnt_q  <= 3'h0;
			shift_q    <= 8'h00;
			addr_q     <= 7'h00;
			is_write_q <= 1'b0;
			phase_q    <= 1'b0;
			wr_tgl_q   <= 1'b0;
			wdata_q    <= 8'h00;
			sd_q       <= 1'b0;
		end
		else if (link.cs_n)
		begin
			bit_cnt_q <= 3'h0;
			phase_q   <= 1'b0;
		end
		else
		begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			shift_q   <= shift_d;
			if (byte_done && !phase_q)
			begin
				is_write_q <= shift_d[MSS_WRITE_BIT];
				addr_q     <= shift_d[6:0];
				phase_q    <= 1'b1;
			end
			else if (byte_done && is_write_q)
			begin
				wdata_q  <= shift_d;
				wr_tgl_q <= ~wr_tgl_q;
				phase_q  <= 1'b0;
				if (addr_q == MSS_ADDR_SHUTDOWN)
				begin
					sd_q <= 1'b1;
				end
			end
			else if (byte_done)
			begin
				phase_q <= 1'b0;
			end
		end
	end

	// Drive out on falling edge, hold to next falling edge
	always_ff @(negedge link.sclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_q <= 8'h00;
		end
		else if (phase_q && !is_write_q && bit_cnt_q == 3'h0)
		begin
			tx_q <= rd_data_in;
		end
		else
		begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	assign link.miso    = tx_q[7];
	assign link.miso_oe = !link.cs_n && phase_q && !is_write_q;
	assign rd_addr_out  = addr_q;

	// ----------------------------------------
	// Crossing to the motion clock
	// ----------------------------------------
	logic [2:0]  wr_sync_q;
	logic [1:0]  sd_sync_q;
	logic [25:0] motion_cnt_q;
	logic        mv_q;
	logic        sdo_q;
	logic        lpo_q;
	wire  logic  wr_evt = wr_sync_q[2] ^ wr_sync_q[1];
	wire  logic  sd_now = sd_sync_q[1];

	always_ff @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_sync_q    <= 3'h0;
			sd_sync_q    <= 2'h0;
			settle_cnt_q <= 9'h000;
			lowp_q       <= 1'b0;
			motion_cnt_q <= 26'h0000000;
			mv_q         <= 1'b0;
			sdo_q        <= 1'b0;
			lpo_q        <= 1'b0;
			wr_stb_out   <= 1'b0;
			wr_addr_out  <= 7'h00;
			wr_data_out  <= 8'h00;
		end
		else
		begin
			wr_sync_q  <= {wr_sync_q[1:0], wr_tgl_q};
			sd_sync_q  <= {sd_sync_q[0], sd_q};
			sdo_q      <= sd_now;
			lpo_q      <= lowp_q;
			// Settle counted on the engine clock so a stopped link clock cannot stall it
			if (!sd_now)
			begin
				settle_cnt_q <= 9'h000;
				lowp_q       <= 1'b0;
			end
			else if (settle_cnt_q >= 9'(MSS_SHUTDOWN_SETTLE - 1))
			begin
				lowp_q <= 1'b1;
			end
			else
			begin
				settle_cnt_q <= settle_cnt_q + 9'h001;
			end
			wr_stb_out <= wr_evt;
			if (wr_evt)
			begin
				wr_addr_out <= addr_q;
				wr_data_out <= wdata_q;
			end
			if (sd_now)
			begin
				motion_cnt_q <= 26'h0000000;
				mv_q         <= 1'b0;
			end
			else if (motion_cnt_q >= 26'(MSS_RESET_TO_MOTION_HOST - 1))
			begin
				mv_q <= 1'b1;
			end
			else
			begin
				motion_cnt_q <= motion_cnt_q + 26'h0000001;
			end
		end
	end

	assign shutdown_out     = sdo_q;
	assign low_power_out    = lpo_q;
	assign motion_valid_out = mv_q;

endmodule

/* File: logic/mss_host.sv */
`timescale 1ns/1ps
module mss_host
	import mss_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_n_in,
	// Link
	mss_link_if.host         link,
	// Command request
	input  wire logic        req_in,
	input  wire logic        req_write_in,
	input  wire logic [6:0]  req_addr_in,
	input  wire logic [7:0]  req_data_in,
	input  wire logic        req_reset_in,
	// Answer
	output logic             busy_out,
	output logic             done_out,
	output logic [7:0]       rd_data_out,
	output logic             need_reset_out
);

	typedef enum logic [2:0] {H_IDLE, H_RST, H_ADDR, H_GAP, H_DATA, H_HOLD} mss_hst_t;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	mss_hst_t    st_q;
	mss_last_t   last_q;
	logic [22:0] cnt_q;
	logic [22:0] gap_q;
	logic [4:0]  div_q;
	logic [3:0]  bit_q;
	logic [7:0]  sh_q;
	logic [7:0]  rx_q;
	logic        wr_q;
	logic [6:0]  a_q;
	logic [7:0]  d_q;
	logic        sclk_q;
	logic        cs_n_q;
	logic        rst_q;
	logic        nrst_q;
	logic [1:0]  miso_s_q;
	wire  logic  half  = (div_q == 5'(MSS_SCLK_HALF_CYC - 1));
	wire  logic  gap_ok = (cnt_q >= gap_q);
	wire  logic  burst = (a_q == MSS_ADDR_MOTION_BURST);
	// Gap before the next command, measured from the previous end
	wire  logic [22:0] gap_w =
		(last_q == MSS_LAST_WRITE) ? 23'(MSS_WRITE_WRITE_GAP) :
		(last_q == MSS_LAST_READ)  ? 23'(MSS_READ_TO_READ_GAP) :
		(last_q == MSS_LAST_BURST) ? 23'(MSS_BURST_EXIT) : 23'h000000;

	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			st_q <= H_IDLE; last_q <= MSS_LAST_NONE; cnt_q <= 23'h0; gap_q <= 23'h0;
			div_q <= 5'h0; bit_q <= 4'h0; sh_q <= 8'h00; rx_q <= 8'h00; wr_q <= 1'b0;
			a_q <= 7'h00; d_q <= 8'h00; sclk_q <= 1'b1; cs_n_q <= 1'b1; rst_q <= 1'b0;
			nrst_q <= 1'b1; miso_s_q <= 2'h0; busy_out <= 1'b0; done_out <= 1'b0;
			rd_data_out <= 8'h00;
		end
		else
		begin
			miso_s_q <= {miso_s_q[0], link.miso};
			done_out <= 1'b0;
			if (cnt_q != 23'h7FFFFF)
				cnt_q <= cnt_q + 23'h1;
			unique case (st_q)
				H_IDLE:
				begin
					busy_out <= 1'b0;
					gap_q    <= gap_w;
					if (req_reset_in)
					begin
						st_q <= H_RST; nrst_q <= 1'b0; cnt_q <= 23'h0; busy_out <= 1'b1;
					end
					else if (req_in && gap_ok)
					begin
						st_q <= H_ADDR; cs_n_q <= 1'b0; busy_out <= 1'b1; div_q <= 5'h0;
						bit_q <= 4'h0; wr_q <= req_write_in; a_q <= req_addr_in;
						d_q <= req_data_in; sh_q <= {req_write_in, req_addr_in};
					end
				end
				H_RST:
				begin
					if (cnt_q == 23'(MSS_HW_RESET_PULSE))
						nrst_q <= 1'b1;
					// Release back to idle one pulse width after the sensor leaves reset;
					// motion validity is the sensor's own business from here
					if (cnt_q == 23'(2 * MSS_HW_RESET_PULSE))
					begin
						st_q <= H_IDLE; rst_q <= 1'b0; last_q <= MSS_LAST_NONE; done_out <= 1'b1;
					end
				end
				H_ADDR, H_DATA:
				begin
					div_q <= half ? 5'h0 : div_q + 5'h1;
					if (half)
					begin
						sclk_q <= ~sclk_q;
						if (!sclk_q)
						begin
							// Rising edge: sensor samples, host samples
							rx_q  <= {rx_q[6:0], miso_s_q[1]};
							bit_q <= bit_q + 4'h1;
							if (bit_q == 4'h7)
							begin
								cnt_q <= 23'h0;
								st_q <= (st_q == H_ADDR) ? H_GAP : H_HOLD;
								gap_q <= (st_q == H_DATA) ? 23'(MSS_WR_CS_HOLD) :
									wr_q ? 23'h0 : 23'(MSS_READ_ADDR_DATA_GAP);
							end
						end
						else if (bit_q != 4'h0 || st_q == H_DATA)
							sh_q <= (bit_q == 4'h0) ? d_q : {sh_q[6:0], 1'b0};
					end
				end
				H_GAP:
				begin
					if (gap_ok)
					begin
						st_q <= H_DATA; bit_q <= 4'h0; div_q <= 5'h0;
					end
				end
				H_HOLD:
				begin
					if (gap_ok || !wr_q)
					begin
						st_q <= H_IDLE; cs_n_q <= 1'b1; cnt_q <= 23'h0; done_out <= 1'b1;
						rd_data_out <= rx_q;
						last_q <= wr_q ? MSS_LAST_WRITE : (burst ? MSS_LAST_BURST : MSS_LAST_READ);
						if (wr_q && a_q == MSS_ADDR_SHUTDOWN)
							rst_q <= 1'b1;
					end
				end
				default: st_q <= H_IDLE;
			endcase
		end
	end

	assign link.sclk       = sclk_q;
	assign link.cs_n       = cs_n_q;
	assign link.mosi       = sh_q[7];
	assign link.hw_reset_n = nrst_q;
	assign need_reset_out  = rst_q;

endmodule

/* File: dv/mss_link_chk.sv */
`timescale 1ns/1ps
module mss_link_chk
	import mss_pkg::*;
(
	// Clock and reset
	input  wire logic mclk_in,
	input  wire logic rst_n_in,
	// Link
	input  wire logic sclk,
	input  wire logic cs_n,
	input  wire logic mosi,
	input  wire logic miso,
	input  wire logic miso_oe
);
	// ----
	// Frame tracking
	// ----
	logic        sclk_q;
	logic [4:0]  bit_q;
	logic        wr_q;
	logic        pwr_q;
	logic [15:0] since_q;
	logic [15:0] last_q;
	logic [15:0] low_q;
	wire         rise = sclk && !sclk_q;
	wire         fall = !sclk && sclk_q;
	wire         end16 = rise && bit_q == 5'h0F;

	// The gap counters since_q and last_q saturate so a long idle never reads as a short gap
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sclk_q  <= 1'h1;
			bit_q   <= 5'h00;
			wr_q    <= 1'h0;
			pwr_q   <= 1'h0;
			since_q <= 16'hFFFF;
			last_q  <= 16'hFFFF;
			low_q   <= 16'h0000;
		end
		else
		begin
			sclk_q  <= sclk;
			bit_q   <= cs_n ? 5'h00 : bit_q + {4'h0, rise};
			wr_q    <= (rise && bit_q == 5'h00) ? mosi : wr_q;
			pwr_q   <= end16 ? wr_q : pwr_q;
			since_q <= rise ? 16'h0000 : since_q + {15'h0000, ~&since_q};
			last_q  <= end16 ? 16'h0000 : last_q + {15'h0000, ~&last_q};
			low_q   <= sclk ? 16'h0000 : low_q + 16'h0001;
		end
	end

	// ----
	// Properties
	// ----
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence s_mosi_held;
		$stable(mosi)[*8];
	endsequence
	property p_rd_gap;
		fall && !cs_n && bit_q == 5'h08 && !wr_q |-> since_q + 1 >= MSS_READ_ADDR_DATA_GAP;
	endproperty
	property p_ww_gap;
		end16 && wr_q && pwr_q |-> last_q + 1 >= MSS_WRITE_WRITE_GAP;
	endproperty
	property p_wr_gap;
		rise && bit_q == 5'h07 && !wr_q && pwr_q |-> last_q + 1 >= MSS_WRITE_TO_READ_GAP;
	endproperty
	property p_rx_gap;
		fall && !cs_n && bit_q == 5'h00 && !pwr_q |-> last_q + 1 >= MSS_READ_TO_READ_GAP;
	endproperty
	property p_cs_hold;
		$rose(cs_n) && bit_q == 5'h10 && wr_q |-> since_q + 1 >= MSS_WR_CS_HOLD;
	endproperty
	property p_low_time;
		rise && !cs_n |-> low_q == MSS_SCLK_HALF_CYC;
	endproperty
	property p_miso_edge;
		miso_oe && $past(miso_oe) && $changed(miso) |-> !sclk;
	endproperty
	property p_mosi_hold;
		rise && !cs_n |-> s_mosi_held;
	endproperty

	a_rd_gap: assert property (p_rd_gap) else $error("read data too soon");
	a_ww_gap: assert property (p_ww_gap) else $error("writes too close");
	a_wr_gap: assert property (p_wr_gap) else $error("read too soon after write");
	a_rx_gap: assert property (p_rx_gap) else $error("command too soon after read");
	a_cs_hold: assert property (p_cs_hold) else $error("select released early");
	a_low_time: assert property (p_low_time) else $error("clock low time wrong");
	a_miso_edge: assert property (p_miso_edge) else $error("output moved while high");
	a_mosi_hold: assert property (p_mosi_hold) else $error("input moved near edge");

endmodule

/* File: dv/test_motion_sensor_spi_command_spacing.sv */
`timescale 1ns/1ps
module test_motion_sensor_spi_command_spacing;
	import mss_pkg::*;
	logic       mclk;
	logic       eclk;
	logic       rst_n;
	logic       req;
	logic       req_wr;
	logic [6:0] req_addr;
	logic [7:0] req_data;
	logic       req_rst;
	logic [7:0] rd_data;
	logic       busy;
	logic       done;
	logic [7:0] rd_q;
	logic       need_rst;
	logic       wr_stb;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic [6:0] rd_addr;
	logic       shut;
	logic       low_pwr;
	logic       mot_ok;
	logic [7:0] seen_addr;
	logic [7:0] seen_data;
	int         n_mismatch;
	int         checked;
	int         n_wr;

	// ----
	// Structure
	// ----
	mss_link_if link();
	mss_host i_mss_host(.mclk_in(mclk), .rst_n_in(rst_n), .link(link), .req_in(req),
		.req_write_in(req_wr), .req_addr_in(req_addr), .req_data_in(req_data),
		.req_reset_in(req_rst), .busy_out(busy), .done_out(done), .rd_data_out(rd_q),
		.need_reset_out(need_rst));
	mss_sensor i_mss_sensor(.link(link), .mclk_in(eclk), .rst_n_in(rst_n),
		.wr_stb_out(wr_stb), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
		.rd_addr_out(rd_addr), .rd_data_in(rd_data), .shutdown_out(shut),
		.low_power_out(low_pwr), .motion_valid_out(mot_ok));
	mss_link_chk i_mss_link_chk(.mclk_in(mclk), .rst_n_in(rst_n), .sclk(link.sclk),
		.cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe));

	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// Engine clock runs at its own period, 32 ns against the host clock's 25 ns, and starts 7 ns late
	initial
	begin
		eclk = 1'b0;
		#7;
		forever #16 eclk = ~eclk;
	end
	always @(posedge eclk)
		if (wr_stb === 1'b1)
		begin
			seen_addr = {1'b0, wr_addr};
			seen_data = wr_data;
			n_wr++;
		end

	// ----
	// Tasks
	// ----
	task automatic end_of_test();
		if (n_mismatch == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Request is held until taken; a gap not yet elapsed keeps it waiting
	task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(negedge mclk);
		req = 1'b1;
		req_wr = w;
		req_addr = a;
		req_data = d;
		while (busy !== 1'b1 && n < 4000)
		begin
			@(negedge mclk);
			n++;
		end
		req = 1'b0;
		while (done !== 1'b1 && n < 12000)
		begin
			@(negedge mclk);
			n++;
		end
		if (n >= 12000)
		begin
			n_mismatch++;
			$display("MISMATCH %0t command never finished", $time);
			end_of_test();
		end
	endtask

	task automatic t_traffic();
		logic [15:0] ops [5] = '{16'h95A5, 16'h823C, 16'h1596, 16'h035C, 16'h9500};
		for (int k = 0; k < 5; k++)
		begin
			rd_data = ops[k][7:0];
			n_wr = 0;
			cmd(ops[k][15], ops[k][14:8], ops[k][7:0]);
			if (ops[k][15])
			begin
				chk(8'(n_wr), 8'h01);
				chk(seen_addr, {1'b0, ops[k][14:8]});
				chk(seen_data, ops[k][7:0]);
			end
			else
			begin
				chk(rd_q, ops[k][7:0]);
				chk({1'b0, rd_addr}, {1'b0, ops[k][14:8]});
			end
		end
	endtask

	task automatic t_shutdown();
		int n;
		chk({7'h00, low_pwr}, 8'h00);
		cmd(1'b1, MSS_ADDR_SHUTDOWN, 8'h00);
		chk({7'h00, shut}, 8'h01);
		chk({7'h00, low_pwr}, 8'h01);
		chk({7'h00, need_rst}, 8'h01);
		chk({7'h00, mot_ok}, 8'h00);
		@(negedge mclk);
		req_rst = 1'b1;
		@(negedge mclk);
		req_rst = 1'b0;
		for (n = 0; n < 2000 && need_rst !== 1'b0; n++)
			@(negedge mclk);
		chk({7'h00, need_rst}, 8'h00);
		repeat (2000) @(negedge mclk);
		chk({7'h00, shut}, 8'h00);
		chk({7'h00, low_pwr}, 8'h00);
		chk({7'h00, mot_ok}, 8'h00);
		rd_data = 8'hC3;
		cmd(1'b0, 7'h02, 8'h00);
		chk(rd_q, 8'hC3);
	endtask

	initial
	begin
		n_mismatch = 0;
		checked = 0;
		n_wr = 0;
		req = 1'b0;
		req_wr = 1'b0;
		req_addr = 7'h00;
		req_data = 8'h00;
		req_rst = 1'b0;
		rd_data = 8'h00;
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		t_traffic();
		t_shutdown();
		end_of_test();
	end

endmodule
